// File: src/crcr_top.sv
/*
  CRC checksum result block with APB slave front end.
  Holds control (enable, width select), status (busy), checksum and
  data registers; the engine and read formatter are instantiated here.
  Assumes an APB master on pclk with 12-bit byte addresses.
*/
`timescale 1ns/1ns
`default_nettype none

module crcr_top
  import crcr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  typedef struct packed {
    logic        en;
    logic        mode32;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } crcr_top_st_t;

  crcr_top_st_t s_r;
  crcr_top_st_t s_nxt;

  crcr_eng_if  e ();
  logic [31:0] sum_rd;
  logic [31:0] wmask;
  logic        setup;
  logic        commit;
  logic        mapped;

  crcr_engine u_engine (
    .pclk    (pclk),
    .presetn (presetn),
    .e       (e)
  );

  crcr_rdfmt u_rdfmt (
    .sum    (e.sum),
    .mode32 (s_r.mode32),
    .busy   (e.busy),
    .rd     (sum_rd)
  );

  // Byte lanes widened to a bit mask
  for (genvar b = 0; b < 4; b++) begin : g_mask
    assign wmask[8*b +: 8] = {8{pstrb[b]}};
  end

  // Setup cycle is taken once; commit is the edge with pready high
  assign setup  = psel && !penable && !s_r.pready;
  assign commit = psel && penable && s_r.pready;
  assign mapped = (paddr == CRCR_OFS_CTRL) || (paddr == CRCR_OFS_STATUS) ||
                  (paddr == CRCR_OFS_SUM)  || (paddr == CRCR_OFS_DATA);

  // Requests to the engine, issued at the commit edge
  always_comb begin
    e.enable     = s_r.en;
    e.mode32     = s_r.mode32;
    e.load       = commit && pwrite && !s_r.pslverr && (paddr == CRCR_OFS_SUM) && !s_r.en;
    e.load_val   = (e.sum & ~wmask) | (pwdata & wmask);
    e.start      = commit && pwrite && !s_r.pslverr && (paddr == CRCR_OFS_DATA) &&
                   pstrb[0] && s_r.en && !e.busy;
    e.start_data = pwdata[7:0];
  end

  // Bus side next state
  always_comb begin
    s_nxt = s_r;
    if (setup) begin
      // Read data captured at setup, held through the access phase
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = !mapped;
      s_nxt.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          CRCR_OFS_CTRL: begin
            s_nxt.prdata[CRCR_CTRL_EN_BIT]     = s_r.en;
            s_nxt.prdata[CRCR_CTRL_MODE32_BIT] = s_r.mode32;
          end
          CRCR_OFS_STATUS: begin
            s_nxt.prdata[CRCR_STAT_BUSY_BIT] = e.busy;
          end
          CRCR_OFS_SUM: begin
            s_nxt.prdata = sum_rd;
          end
          default: begin
            s_nxt.prdata = 32'h0000_0000;
          end
        endcase
      end
    end else if (commit) begin
      s_nxt.pready  = 1'b0;
      s_nxt.pslverr = 1'b0;
      if (pwrite && (paddr == CRCR_OFS_CTRL) && pstrb[0]) begin
        // Clearing enable aborts a running byte
        s_nxt.en     = pwdata[CRCR_CTRL_EN_BIT];
        s_nxt.mode32 = pwdata[CRCR_CTRL_MODE32_BIT];
      end
    end else begin
      // Master dropped the request early
      s_nxt.pready  = 1'b0;
      s_nxt.pslverr = 1'b0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.en      <= CRCR_EN_RESET;
      s_r.mode32  <= CRCR_MODE32_RESET;
      s_r.prdata  <= 32'h0000_0000;
      s_r.pready  <= 1'b0;
      s_r.pslverr <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata  = s_r.prdata;
  assign pready  = s_r.pready;
  assign pslverr = s_r.pslverr;

endmodule

`default_nettype wire

// File: src/crcr_pkg.sv
/*
  Shared constants and types of the CRC checksum result block:
  register offsets, field positions, reset values, polynomials, states.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
package crcr_pkg;

  // Register byte offsets
  localparam logic [11:0] CRCR_OFS_CTRL   = 12'h000;
  localparam logic [11:0] CRCR_OFS_STATUS = 12'h004;
  localparam logic [11:0] CRCR_OFS_SUM    = 12'h008;
  localparam logic [11:0] CRCR_OFS_DATA   = 12'h00c;

  // Field positions
  localparam int CRCR_CTRL_EN_BIT     = 0;
  localparam int CRCR_CTRL_MODE32_BIT = 1;
  localparam int CRCR_STAT_BUSY_BIT   = 0;

  // Values after reset
  localparam logic [31:0] CRCR_SUM_RESET    = 32'h0000_0000;
  localparam logic        CRCR_EN_RESET     = 1'b0;
  localparam logic        CRCR_MODE32_RESET = 1'b0;

  // Generator polynomials, normal form, shifted most significant bit first
  localparam logic [31:0] CRCR_POLY32 = 32'h04c1_1db7;
  localparam logic [15:0] CRCR_POLY16 = 16'h1021;

  // Bit steps per data byte, counted 0..7
  localparam logic [2:0] CRCR_LAST_BIT = 3'h7;

  // Engine states, Gray coded
  typedef enum logic [1:0] {
    CRCR_ST_IDLE = 2'b00,
    CRCR_ST_RUN  = 2'b01
  } crcr_state_t;

endpackage

// File: src/crcr_eng_if.sv
/*
  Carrier between the register front end and the CRC engine.
  Assumes both ends run on the same pclk.
*/
`timescale 1ns/1ns
`default_nettype none

interface crcr_eng_if;
  logic        load;       // Software preset of the checksum
  logic [31:0] load_val;
  logic        start;      // Begin one byte
  logic [7:0]  start_data;
  logic        enable;     // Module enable, low aborts
  logic        mode32;     // 1: CRC-32, 0: CRC-16
  logic        busy;
  logic [31:0] sum;

  modport ctl (output load, output load_val, output start, output start_data,
               output enable, output mode32, input busy, input sum);
  modport eng (input load, input load_val, input start, input start_data,
               input enable, input mode32, output busy, output sum);
endinterface

`default_nettype wire

// File: src/crcr_engine.sv
/*
  CRC engine: holds the checksum register and shifts one byte per
  start, one bit per clock. Assumes the front end only loads while
  disabled and only starts while enabled and idle.
*/
`timescale 1ns/1ns
`default_nettype none

module crcr_engine
  import crcr_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  crcr_eng_if.eng   e
);

  typedef struct packed {
    crcr_state_t st;
    logic [2:0]  cnt;
    logic [7:0]  data;
    logic [31:0] sum;
  } crcr_eng_st_t;

  crcr_eng_st_t s_r;
  crcr_eng_st_t s_nxt;

  // Next state: preset, start, bit step, abort
  always_comb begin
    logic fb;
    fb    = 1'b0;
    s_nxt = s_r;
    case (s_r.st)
      CRCR_ST_IDLE: begin
        if (e.load) begin
          s_nxt.sum = e.load_val;
        end else if (e.enable && e.start) begin
          s_nxt.data = e.start_data;
          s_nxt.cnt  = 3'h0;
          s_nxt.st   = CRCR_ST_RUN;
        end
      end
      CRCR_ST_RUN: begin
        if (!e.enable) begin
          // Abort leaves the partial sum in place
          s_nxt.st = CRCR_ST_IDLE;
        end else begin
          if (e.mode32) begin
            fb        = s_r.sum[31] ^ s_r.data[7];
            s_nxt.sum = {s_r.sum[30:0], 1'b0} ^ (fb ? CRCR_POLY32 : 32'h0000_0000);
          end else begin
            // Upper half untouched in 16-bit mode
            fb               = s_r.sum[15] ^ s_r.data[7];
            s_nxt.sum[15:0]  = {s_r.sum[14:0], 1'b0} ^ (fb ? CRCR_POLY16 : 16'h0000);
          end
          s_nxt.data = {s_r.data[6:0], 1'b0};
          s_nxt.cnt  = s_r.cnt + 3'h1;
          if (s_r.cnt == CRCR_LAST_BIT) begin
            s_nxt.st = CRCR_ST_IDLE;
          end
        end
      end
      default: begin
        s_nxt.st = CRCR_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.st   <= CRCR_ST_IDLE;
      s_r.cnt  <= 3'h0;
      s_r.data <= 8'h00;
      s_r.sum  <= CRCR_SUM_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Status back to the front end
  assign e.busy = (s_r.st == CRCR_ST_RUN);
  assign e.sum  = s_r.sum;

endmodule

`default_nettype wire

// File: src/crcr_rdfmt.sv
/*
  Read formatter of the checksum: reversal and complement for a
  finished CRC-32, raw value otherwise, upper half zero in CRC-16.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ns
`default_nettype none

module crcr_rdfmt (
  input  wire logic [31:0] sum,
  input  wire logic        mode32,
  input  wire logic        busy,
  output logic      [31:0] rd
);

  logic [31:0] rev;

  // Bit i swaps with bit 31-i
  for (genvar i = 0; i < 32; i++) begin : g_rev
    assign rev[i] = sum[31 - i];
  end

  // Only a settled CRC-32 is presented in final form
  always_comb begin
    if (!mode32) begin
      rd = {16'h0000, sum[15:0]};
    end else if (busy) begin
      rd = sum;
    end else begin
      rd = ~rev;
    end
  end

endmodule

`default_nettype wire

// File: tb/crcr_asserts.sv
/* Port checker of crcr_top: APB timing and checksum read format.
   Assumes the APB contract of the block and the bind below. */
`timescale 1ns/1ns
`default_nettype none
module crcr_asserts
  import crcr_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic [31:0] sum_r;
  logic        en_r;
  logic        m32_r;
  logic        ok_r;
  logic [3:0]  bcnt_r;
  wire         cm = psel && penable && pready && pwrite && !pslverr;
  wire         rd = psel && !penable && !pwrite;
  wire  [31:0] rev = {<<{sum_r}};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of preset, control bits and busy span; ok_r drops once data is fed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_r <= 32'h0;
      en_r <= 1'b0;
      m32_r <= 1'b0;
      ok_r <= 1'b1;
      bcnt_r <= 4'h0;
    end else begin
      if (bcnt_r != 4'h0) bcnt_r <= bcnt_r - 4'h1;
      if (cm && paddr == CRCR_OFS_CTRL && pstrb[0]) begin
        en_r <= pwdata[0];
        m32_r <= pwdata[1];
        if (!pwdata[0] && bcnt_r > 4'h1) bcnt_r <= 4'h1; // Abort drops busy next edge
      end
      if (cm && paddr == CRCR_OFS_SUM && !en_r) begin
        ok_r <= 1'b1;
        for (int i = 0; i < 4; i++) if (pstrb[i]) sum_r[8*i+:8] <= pwdata[8*i+:8];
      end
      if (cm && paddr == CRCR_OFS_DATA && pstrb[0] && en_r && bcnt_r == 4'h0) begin
        bcnt_r <= 4'h8;
        ok_r <= 1'b0;
      end
    end
  end
  sequence sum_rd;
    rd && paddr == CRCR_OFS_SUM && ok_r;
  endsequence
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (psel && !penable && paddr > CRCR_OFS_DATA |=> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && !penable && paddr == CRCR_OFS_SUM |=> !pslverr)
    else $error("checksum access refused");
  sum16_read_a: assert property (sum_rd ##0 !m32_r |=> prdata == {16'h0, sum_r[15:0]})
    else $error("raw checksum read wrong");
  sum32_read_a: assert property (sum_rd ##0 m32_r |=> prdata == ~rev)
    else $error("finished crc32 read wrong");
  upper_zero_a: assert property (rd && paddr == CRCR_OFS_SUM && !m32_r |=> prdata[31:16] == 16'h0)
    else $error("upper half not zero");
  busy_flag_a: assert property (rd && paddr == CRCR_OFS_STATUS |=> prdata[0] == ($past(bcnt_r) != 4'h0))
    else $error("busy flag wrong");
endmodule
bind crcr_top crcr_asserts chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr);
`default_nettype wire

// File: tb/testbench.sv
/* Self-checking bench of crcr_top over APB.
   Assumes one pclk domain and the registers of crcr_pkg. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import crcr_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, sum = 0, v, dv, seed = 32'h8237;
  logic [3:0]  pstrb = 0;
  logic [31:0] prdata;
  logic        pready, pslverr, m;
  logic [64:0] e;
  logic [64:0] exp_q[$]; // Notes: refused bit, mask, value
  int          err_count = 0, samples_checked = 0;
  crcr_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr);
  always #10 pclk = ~pclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Bit order reversal; a stream operator may not stand inside an expression
  function automatic logic [31:0] rev32(input logic [31:0] x);
    logic [31:0] r;
    for (int k = 0; k < 32; k++) r[k] = x[31 - k];
    return r;
  endfunction
  // Reference byte step, MSB first, polynomials from the package
  function automatic logic [31:0] crc_byte(input logic [31:0] s, input logic [7:0] d, input logic w32);
    logic [31:0] t;
    t = s;
    for (int k = 7; k >= 0; k--) begin
      if (w32) t = {t[30:0], 1'b0} ^ ((t[31] ^ d[k]) ? CRCR_POLY32 : 32'h0000_0000);
      else t[15:0] = {t[14:0], 1'b0} ^ ((t[15] ^ d[k]) ? CRCR_POLY16 : 16'h0000);
    end
    return t;
  endfunction
  // Request held until pready; release left to the next setup or idle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
  endtask
  task automatic rd(input logic [11:0] a, input logic [64:0] x);
    exp_q.push_back(x);
    xfer(0, a, 32'h0, 4'hf);
  endtask
  task automatic idle(input int n);
    psel <= 0;
    penable <= 0;
    repeat (n) @(posedge pclk);
  endtask
  task automatic conclude();
    if (exp_q.size() != 0) err_count++; // Reads that never completed
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Read results compared in order against the notes
  always @(posedge pclk) if (pready === 1'b1 && psel && !pwrite && exp_q.size() > 0) begin
    e = exp_q.pop_front();
    samples_checked++;
    if ((prdata & e[63:32]) !== e[31:0] || pslverr !== e[64]) begin
      err_count++;
      $display("ERROR prdata expected %h seen %h", e[31:0], prdata);
    end
  end
  initial begin #200000; err_count++; conclude(); end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(CRCR_OFS_SUM, {1'b0, 32'hffffffff, 32'h0});
    // Random presets and lanes, widths alternating; no check skipped on a zero strobe
    for (int i = 0; i < 8; i++) begin
      m = i[0];
      v = rnd();
      xfer(1, CRCR_OFS_CTRL, {30'h0, m, 1'b0}, 4'hf);
      xfer(1, CRCR_OFS_SUM, v, v[3:0]);
      for (int b = 0; b < 4; b++) if (v[b]) sum[8*b+:8] = v[8*b+:8];
      rd(CRCR_OFS_SUM, {1'b0, 32'hffffffff, m ? ~rev32(sum) : {16'h0, sum[15:0]}});
    end
    // CRC-32 byte: raw value while busy, final form once idle
    v = rnd();
    dv = rnd();
    xfer(1, CRCR_OFS_SUM, v, 4'hf);
    xfer(1, CRCR_OFS_CTRL, 32'h3, 4'hf);
    xfer(1, CRCR_OFS_DATA, dv, 4'hf);
    rd(CRCR_OFS_SUM, {1'b0, 32'hffffffff, v});
    idle(10);
    sum = crc_byte(v, dv[7:0], 1'b1);
    rd(CRCR_OFS_SUM, {1'b0, 32'hffffffff, ~rev32(sum)});
    // CRC-16 byte: upper stored half untouched, read as zero
    xfer(1, CRCR_OFS_CTRL, 32'h0, 4'hf);
    xfer(1, CRCR_OFS_SUM, v, 4'hf);
    xfer(1, CRCR_OFS_CTRL, 32'h1, 4'hf);
    xfer(1, CRCR_OFS_DATA, dv, 4'hf);
    idle(10);
    sum = crc_byte(v, dv[7:0], 1'b0);
    rd(CRCR_OFS_SUM, {1'b0, 32'hffffffff, 16'h0, sum[15:0]});
    xfer(1, CRCR_OFS_CTRL, 32'h1, 4'hf);
    xfer(1, CRCR_OFS_SUM, ~sum, 4'hf);
    rd(CRCR_OFS_SUM, {1'b0, 32'hffffffff, 16'h0, sum[15:0]});
    xfer(1, CRCR_OFS_DATA, rnd(), 4'hf);
    rd(CRCR_OFS_STATUS, {1'b0, 32'h1, 32'h1});
    idle(10);
    rd(CRCR_OFS_STATUS, {1'b0, 32'h1, 32'h0});
    xfer(1, CRCR_OFS_DATA, rnd(), 4'hf);
    xfer(1, CRCR_OFS_CTRL, 32'h0, 4'hf);
    rd(CRCR_OFS_STATUS, {1'b0, 32'h1, 32'h1});
    idle(1);
    rd(CRCR_OFS_STATUS, {1'b0, 32'h1, 32'h0});
    xfer(1, CRCR_OFS_DATA, rnd(), 4'hf);
    rd(CRCR_OFS_STATUS, {1'b0, 32'h1, 32'h0});
    xfer(1, 12'h010, rnd(), 4'hf);
    rd(12'h010, {1'b1, 32'hffffffff, 32'h0});
    // Second reset while idle must clear a preset of all ones
    xfer(1, CRCR_OFS_SUM, 32'hffff_ffff, 4'hf);
    idle(3);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    sum = 32'h0000_0000;
    xfer(1, CRCR_OFS_CTRL, 32'h2, 4'hf);
    rd(CRCR_OFS_SUM, {1'b0, 32'hffffffff, ~rev32(sum)});
    idle(3);
    conclude();
  end
endmodule
`default_nettype wire
